// ===== logic/stf_pkg.sv
// shared constants, types and register map of the trigger/acquisition sequencer
package stf_pkg;
  // ****************************************
  // widths
  // ****************************************
  localparam int STF_AW = 26;
  localparam int STF_DW = 16;
  localparam int STF_PW = 16;
  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [5:0] OFS_CTRL   = 6'h00;
  localparam logic [5:0] OFS_TMASK  = 6'h04;
  localparam logic [5:0] OFS_PWID   = 6'h08;
  localparam logic [5:0] OFS_DELAY  = 6'h0c;
  localparam logic [5:0] OFS_PRE    = 6'h10;
  localparam logic [5:0] OFS_POSTL  = 6'h14;
  localparam logic [5:0] OFS_POSTH  = 6'h18;
  localparam logic [5:0] OFS_MEMSZ  = 6'h1c;
  localparam logic [5:0] OFS_SEGSZ  = 6'h20;
  localparam logic [5:0] OFS_SLDIV  = 6'h24;
  localparam logic [5:0] OFS_SYDIV  = 6'h28;
  localparam logic [5:0] OFS_STATUS = 6'h2c;
  localparam logic [5:0] OFS_TSCNT  = 6'h30;
  // ****************************************
  // control field positions
  // ****************************************
  localparam int CB_MODE   = 0;
  localparam int CB_START  = 3;
  localparam int CB_STOP   = 4;
  localparam int CB_TOEN   = 5;
  localparam int CB_EDGE   = 6;
  localparam int CB_AND    = 8;
  localparam int CB_PWM    = 9;
  localparam int CB_GPOL   = 11;
  localparam int CB_CHLG   = 12;
  localparam int CB_TSZERO = 14;
  // ****************************************
  // limits and reset values
  // ****************************************
  localparam logic [32:0] PRE_MAX  = 33'h0_0000_1ff0;
  localparam logic [32:0] POST_MAX = 33'h1_ffff_fffc;
  localparam logic [32:0] LEN_MIN  = 33'h0_0000_0004;
  localparam logic [32:0] SEG_MIN  = 33'h0_0000_0008;
  localparam logic [32:0] DIV_MIN  = 33'h0_0000_0008;
  localparam logic [32:0] DIV_MAX  = 33'h0_0007_fff8;
  localparam logic [32:0] SYN_MIN  = 33'h0_0000_0002;
  localparam logic [32:0] SYN_MAX  = 33'h0_0000_1ffe;
  localparam logic [32:0] M_STEP4  = 33'h0_0000_0003;
  localparam logic [32:0] M_STEP8  = 33'h0_0000_0007;
  localparam logic [32:0] M_STEP2  = 33'h0_0000_0001;
  localparam logic [31:0] RST_SIZE = 32'h0000_0400;
  localparam logic [1:0]  ED_RISE  = 2'h0;
  localparam logic [1:0]  ED_FALL  = 2'h1;
  localparam logic [1:0]  PW_LONG  = 2'h1;
  localparam logic [1:0]  PW_SHORT = 2'h2;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    MD_RING = 3'h0, MD_SEG = 3'h1, MD_GATE = 3'h2, MD_FIFO = 3'h3, MD_DUAL = 3'h4
  } stf_mode_type;
  typedef enum logic [4:0] {
    S_IDLE = 5'h01, S_PRE = 5'h02, S_ARM = 5'h04, S_POST = 5'h08, S_DONE = 5'h10
  } stf_state_type;
  typedef struct packed {
    logic        read;
    logic        write;
    logic [5:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } stf_bus_type;
  typedef struct packed {
    logic              we;
    logic [STF_AW-1:0] addr;
    logic [STF_DW-1:0] data;
  } stf_mem_type;
  typedef struct packed {
    logic        we;
    logic [15:0] seg;
    logic [47:0] stamp;
  } stf_ts_type;
endpackage

// ===== logic/stf_acq.sv
// trigger qualification and segmented acquisition sequencer with avalon-mm registers
//
// Design decisions made here: the Avalon-MM register port and the address map.
module stf_acq
  import stf_pkg::*;
#(
  parameter int NSRC = 8
) (
  // clock and reset
  input  wire logic           sys_clk,
  input  wire logic           nrst,
  // register bus
  input  wire stf_pkg::stf_bus_type avs_req,
  output logic [31:0]         avs_readdata,
  output logic                avs_waitrequest,
  // sample stream and trigger inputs
  input  wire logic           smp_valid,
  input  wire logic [stf_pkg::STF_DW-1:0] smp_data,
  input  wire logic [NSRC-1:0] trg_src,
  input  wire logic           gate_in,
  // memory, timestamps and outputs
  output stf_pkg::stf_mem_type fast_mem,
  output stf_pkg::stf_mem_type slow_mem,
  output stf_pkg::stf_ts_type  ts_mem,
  output logic                trig_out,
  output logic                fifo_irq,
  output logic                sync_out
);
  import stf_pkg::*;
  localparam int SW = STF_AW + 1;
  if (NSRC < 1 || NSRC > 32) begin : g_chk
    $error("NSRC must be 1 to 32");
  end

  function automatic logic [32:0] clampm(input logic [32:0] v, lo, hi, m);
    logic [32:0] r;
    r = (v < lo) ? lo : ((v > hi) ? hi : v);
    return r & ~m;
  endfunction

  function automatic logic [31:0] bmerge(input logic [31:0] o, w, input logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = w[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ****************************************
  // reset release
  // ****************************************
  logic rs1_q;
  logic rst_n;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rs1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rst_n <= rs1_q;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  logic [31:0] ctrl_q, ctrl_d, tmask_q, tmask_d, pwid_q, pwid_d, dly_q, dly_d;
  logic [31:0] pre_q, pre_d, postl_q, postl_d, posth_q, posth_d, msz_q, msz_d;
  logic [31:0] seg_q, seg_d, sldiv_q, sldiv_d, sydiv_q, sydiv_d;
  logic [31:0] rdat_q, rdat_d;
  logic        wait_q, wait_d, wacc, go, stop, tzero;
  logic [31:0] rmux;
  stf_state_type st_q, st_d;
  logic [15:0] nseg_q, nseg_d;
  logic [47:0] tcnt_q, tcnt_d;

  assign wacc  = avs_req.write && !wait_q;
  assign go    = wacc && avs_req.address == OFS_CTRL && avs_req.byteenable[0] && avs_req.writedata[CB_START];
  assign stop  = wacc && avs_req.address == OFS_CTRL && avs_req.byteenable[0] && avs_req.writedata[CB_STOP];
  assign tzero = wacc && avs_req.address == OFS_CTRL && avs_req.byteenable[1] && avs_req.writedata[CB_TSZERO];

  always_comb begin
    unique case (avs_req.address)
      OFS_CTRL:   rmux = ctrl_q;
      OFS_TMASK:  rmux = tmask_q;
      OFS_PWID:   rmux = pwid_q;
      OFS_DELAY:  rmux = dly_q;
      OFS_PRE:    rmux = pre_q;
      OFS_POSTL:  rmux = postl_q;
      OFS_POSTH:  rmux = posth_q;
      OFS_MEMSZ:  rmux = msz_q;
      OFS_SEGSZ:  rmux = seg_q;
      OFS_SLDIV:  rmux = sldiv_q;
      OFS_SYDIV:  rmux = sydiv_q;
      OFS_STATUS: rmux = {nseg_q, 11'h000, st_q};
      OFS_TSCNT:  rmux = tcnt_q[31:0];
      default:    rmux = 32'h0000_0000;
    endcase
    // one wait cycle per access, then the answer stands for a single cycle
    wait_d = !((avs_req.read || avs_req.write) && wait_q);
    rdat_d = (avs_req.read && wait_q) ? rmux : rdat_q;
    ctrl_d = ctrl_q; tmask_d = tmask_q; pwid_d = pwid_q; dly_d = dly_q;
    pre_d = pre_q; postl_d = postl_q; posth_d = posth_q; msz_d = msz_q;
    seg_d = seg_q; sldiv_d = sldiv_q; sydiv_d = sydiv_q;
    if (wacc) begin
      unique case (avs_req.address)
        OFS_CTRL:  ctrl_d  = bmerge(ctrl_q, avs_req.writedata, avs_req.byteenable);
        OFS_TMASK: tmask_d = bmerge(tmask_q, avs_req.writedata, avs_req.byteenable);
        OFS_PWID:  pwid_d  = bmerge(pwid_q, avs_req.writedata, avs_req.byteenable);
        OFS_DELAY: dly_d   = bmerge(dly_q, avs_req.writedata, avs_req.byteenable);
        OFS_PRE:   pre_d   = bmerge(pre_q, avs_req.writedata, avs_req.byteenable);
        OFS_POSTL: postl_d = bmerge(postl_q, avs_req.writedata, avs_req.byteenable);
        OFS_POSTH: posth_d = bmerge(posth_q, avs_req.writedata, avs_req.byteenable);
        OFS_MEMSZ: msz_d   = bmerge(msz_q, avs_req.writedata, avs_req.byteenable);
        OFS_SEGSZ: seg_d   = bmerge(seg_q, avs_req.writedata, avs_req.byteenable);
        OFS_SLDIV: sldiv_d = bmerge(sldiv_q, avs_req.writedata, avs_req.byteenable);
        OFS_SYDIV: sydiv_d = bmerge(sydiv_q, avs_req.writedata, avs_req.byteenable);
        default: ;
      endcase
      // start, stop and zero bits are strobes and never stick
      ctrl_d[CB_START] = 1'b0;
      ctrl_d[CB_STOP] = 1'b0;
      ctrl_d[CB_TSZERO] = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 1'b1; rdat_q <= 32'h0000_0000;
      ctrl_q <= 32'h0000_0000; tmask_q <= 32'h0000_0000;
      pwid_q <= 32'h0000_0000; dly_q <= 32'h0000_0000;
      pre_q <= 32'h0000_0004; postl_q <= 32'h0000_0100; posth_q <= 32'h0000_0000;
      msz_q <= RST_SIZE; seg_q <= RST_SIZE; sldiv_q <= 32'h0000_0008; sydiv_q <= 32'h0000_0002;
    end else begin
      wait_q <= wait_d; rdat_q <= rdat_d;
      ctrl_q <= ctrl_d; tmask_q <= tmask_d; pwid_q <= pwid_d; dly_q <= dly_d;
      pre_q <= pre_d; postl_q <= postl_d; posth_q <= posth_d; msz_q <= msz_d;
      seg_q <= seg_d; sldiv_q <= sldiv_d; sydiv_q <= sydiv_d;
    end
  end
  assign avs_readdata    = rdat_q;
  assign avs_waitrequest = wait_q;

  // ****************************************
  // effective settings
  // ****************************************
  stf_mode_type md, md_go;
  logic [1:0]  lg;
  logic [32:0] mlim, msz_e, seg_e, pre_e, post_e, div_e, syn_e, rsz;
  assign md = stf_mode_type'(ctrl_q[CB_MODE +: 3]);
  assign md_go = stf_mode_type'(avs_req.writedata[CB_MODE +: 3]);
  assign lg = ctrl_q[CB_CHLG +: 2];
  always_comb begin
    mlim   = (33'h0_0000_0001 << STF_AW) >> lg;
    msz_e  = clampm({1'b0, msz_q}, SEG_MIN, mlim, M_STEP4);
    seg_e  = clampm({1'b0, seg_q}, SEG_MIN, mlim >> 1, M_STEP4);
    if (seg_e > msz_e) begin
      seg_e = msz_e;
    end
    pre_e  = clampm({1'b0, pre_q}, LEN_MIN, PRE_MAX >> lg, M_STEP4);
    if (pre_e >= seg_e) begin
      pre_e = seg_e - LEN_MIN;
    end
    post_e = clampm({posth_q[0], postl_q}, LEN_MIN, POST_MAX, M_STEP4);
    div_e  = clampm({1'b0, sldiv_q}, DIV_MIN, DIV_MAX, M_STEP8);
    syn_e  = clampm({1'b0, sydiv_q}, SYN_MIN, SYN_MAX, M_STEP2);
    rsz    = (md == MD_RING || md == MD_FIFO) ? msz_e : seg_e;
  end

  // ****************************************
  // trigger qualification
  // ****************************************
  logic [NSRC-1:0] prv_q, ev;
  logic [NSRC-1:0] msk;
  logic            lvl, lvl_q, edg, pend, fire;
  logic [STF_PW-1:0] pwc_q, pwc_d, dcnt_q, dcnt_d;
  logic            dact_q, dact_d;
  assign msk = tmask_q[NSRC-1:0];
  for (genvar i = 0; i < NSRC; i++) begin : g_src
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        prv_q[i] <= 1'b0;
      end else if (smp_valid) begin
        prv_q[i] <= trg_src[i];
      end
    end
    // masks apply regardless of which channels are recorded
    assign ev[i] = msk[i] && (
      (ctrl_q[CB_EDGE +: 2] != ED_FALL && trg_src[i] && !prv_q[i]) ||
      (ctrl_q[CB_EDGE +: 2] != ED_RISE && !trg_src[i] && prv_q[i]));
  end
  always_comb begin
    lvl  = ctrl_q[CB_AND] ? &(trg_src | ~msk) && |msk : |(trg_src & msk);
    edg  = ctrl_q[CB_AND] ? lvl && |ev : |ev;
    pwc_d = lvl ? ((pwc_q == '1) ? pwc_q : pwc_q + 1'b1) : '0;
    unique case (ctrl_q[CB_PWM +: 2])
      PW_LONG:  pend = smp_valid && lvl_q && !lvl && pwc_q > pwid_q[STF_PW-1:0];
      PW_SHORT: pend = smp_valid && lvl_q && !lvl && pwc_q < pwid_q[STF_PW-1:0];
      default:  pend = smp_valid && edg;
    endcase
    dact_d = dact_q;
    dcnt_d = dcnt_q;
    fire   = 1'b0;
    if (smp_valid && dact_q) begin
      dcnt_d = dcnt_q - 1'b1;
      if (dcnt_q == 1) begin
        dact_d = 1'b0;
        fire   = 1'b1;
      end
    end else if (pend) begin
      if (dly_q[STF_PW-1:0] == '0) begin
        fire = 1'b1;
      end else begin
        dact_d = 1'b1;
        dcnt_d = dly_q[STF_PW-1:0];
      end
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lvl_q <= 1'b0; pwc_q <= '0; dcnt_q <= '0; dact_q <= 1'b0;
    end else begin
      if (smp_valid) begin
        lvl_q <= lvl;
        pwc_q <= pwc_d;
      end
      dcnt_q <= dcnt_d; dact_q <= dact_d;
    end
  end

  // ****************************************
  // acquisition sequencer
  // ****************************************
  logic [STF_AW-1:0] off_q, off_d, base_q, base_d, sp_q, sp_d;
  logic [32:0]  cnt_q, cnt_d;
  logic [19:0]  slc_q, slc_d;
  logic [12:0]  syc_q, syc_d;
  logic [13:0]  rac_q, rac_d;
  logic         gact, hit, acc, irq_d, tout_d, sync_d, last;
  stf_mem_type  fm_d, sm_d, fm_q, sm_q;
  stf_ts_type   ts_d, ts_q;
  logic         tout_q, irq_q, sync_q;
  assign gact = (gate_in == ctrl_q[CB_GPOL]);
  assign hit  = (md == MD_GATE) ? gact : fire;
  always_comb begin
    st_d = st_q; off_d = off_q; base_d = base_q; cnt_d = cnt_q; nseg_d = nseg_q;
    sp_d = sp_q; slc_d = slc_q; syc_d = syc_q; sync_d = sync_q;
    rac_d = (st_q != S_PRE) ? '0 : rac_q + 14'(smp_valid);
    acc = 1'b0; irq_d = 1'b0; last = 1'b0;
    tcnt_d = tzero ? '0 : (smp_valid ? tcnt_q + 1'b1 : tcnt_q);
    fm_d = '0;
    fm_d.addr = base_q + off_q;
    fm_d.data = smp_data;
    sm_d = '0;
    sm_d.addr = sp_q;
    sm_d.data = smp_data;
    tout_d = fire && ctrl_q[CB_TOEN];
    if (smp_valid) begin
      syc_d = (33'(syc_q) + 1'b1 >= (syn_e >> 1)) ? '0 : syc_q + 1'b1;
      sync_d = (syc_d == '0) ? !sync_q : sync_q;
    end
    unique case (st_q)
      S_IDLE, S_DONE: begin
        if (go) begin
          st_d = (md_go == MD_RING || md_go == MD_FIFO) ? S_ARM : S_PRE;
          off_d = '0; base_d = '0; cnt_d = '0; nseg_d = '0; sp_d = '0; slc_d = '0;
          tcnt_d = '0;
        end
      end
      S_PRE, S_ARM, S_POST: begin
        if (smp_valid) begin
          // pre-area keeps circling inside its own segment until the hit
          fm_d.we = 1'b1;
          off_d = (33'(off_q) + 1'b1 >= rsz) ? '0 : off_q + 1'b1;
          if (md == MD_DUAL) begin
            slc_d = (33'(slc_q) + 1'b1 >= div_e) ? '0 : slc_q + 1'b1;
            sm_d.we = (slc_q == '0);
            sp_d = sm_d.we ? ((33'(sp_q) + 1'b1 >= msz_e) ? '0 : sp_q + 1'b1) : sp_q;
          end
          if (md == MD_FIFO) begin
            irq_d = (33'(off_q) + 1'b1 == rsz) || (33'(off_q) + 1'b1 == (rsz >> 1));
            acc = (st_q == S_ARM) && hit;
          end else if (st_q == S_PRE) begin
            cnt_d = cnt_q + 1'b1;
            if (cnt_q + 1'b1 >= pre_e) begin
              st_d = S_ARM;
            end
          end else if (st_q == S_ARM) begin
            if (hit) begin
              acc = 1'b1;
              st_d = S_POST;
              cnt_d = post_e;
            end
          end else if (md == MD_GATE && gact) begin
            cnt_d = post_e;
          end else if (cnt_q <= 33'h0_0000_0001) begin
            last = 1'b1;
            nseg_d = nseg_q + 1'b1;
            if (md == MD_RING || 34'(base_q) + 34'(rsz) + 34'(rsz) > 34'(msz_e)) begin
              st_d = S_DONE;
            end else begin
              base_d = base_q + rsz[STF_AW-1:0];
              off_d = '0;
              cnt_d = '0;
              st_d = S_PRE;
            end
          end else begin
            cnt_d = cnt_q - 1'b1;
          end
        end
        if (stop) begin
          st_d = S_DONE;
        end
      end
      default: st_d = S_IDLE;
    endcase
    ts_d = '0;
    ts_d.we = acc;
    ts_d.seg = nseg_q;
    ts_d.stamp = tcnt_q;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= S_IDLE; off_q <= '0; base_q <= '0; cnt_q <= '0; nseg_q <= '0;
      sp_q <= '0; slc_q <= '0; syc_q <= '0; sync_q <= 1'b0; tcnt_q <= '0; rac_q <= '0;
      fm_q <= '0; sm_q <= '0; ts_q <= '0; tout_q <= 1'b0; irq_q <= 1'b0;
    end else begin
      st_q <= st_d; off_q <= off_d; base_q <= base_d; cnt_q <= cnt_d; nseg_q <= nseg_d;
      sp_q <= sp_d; slc_q <= slc_d; syc_q <= syc_d; sync_q <= sync_d; tcnt_q <= tcnt_d; rac_q <= rac_d;
      fm_q <= fm_d; sm_q <= sm_d; ts_q <= ts_d; tout_q <= tout_d; irq_q <= irq_d;
    end
  end
  assign fast_mem = fm_q;
  assign slow_mem = sm_q;
  assign ts_mem   = ts_q;
  assign trig_out = tout_q;
  assign fifo_irq = irq_q;
  assign sync_out = sync_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_fire;
    fire && ctrl_q[CB_TOEN];
  endsequence
  sequence s_hit;
    st_q == S_ARM && smp_valid && hit && !stop;
  endsequence
  a_trig_out_delay: assert property (s_fire |=> trig_out)
    else $error("trigger output not one edge after trigger");
  a_trig_out_off: assert property (!ctrl_q[CB_TOEN] |=> !trig_out)
    else $error("trigger output while disabled");
  a_ts_stamp: assert property (s_hit |=> ts_mem.we && ts_mem.stamp == $past(tcnt_q))
    else $error("timestamp missing or wrong");
  a_hit_post: assert property ((s_hit ##0 (md != MD_FIFO)) |=> st_q == S_POST && cnt_q == $past(post_e))
    else $error("posttrigger not loaded on hit");
  a_seg_rearm: assert property (st_q == S_PRE && (md == MD_SEG || md == MD_GATE)
    |-> 33'(rac_q) < pre_e + LEN_MIN)
    else $error("re-arm too slow");
  a_pre_below: assert property (pre_e < seg_e && pre_e >= LEN_MIN)
    else $error("pretrigger not below segment size");
  a_div_step: assert property (div_e >= DIV_MIN && div_e <= DIV_MAX && div_e[2:0] == 3'h0)
    else $error("slow divider out of range");
  a_gate_hold: assert property (st_q == S_POST && md == MD_GATE && gact && smp_valid && !stop
    |=> st_q == S_POST && cnt_q == $past(post_e))
    else $error("gate interval ended early");
  a_bus_answer: assert property ((avs_req.read || avs_req.write) && wait_q |=> !avs_waitrequest)
    else $error("bus answer late");
endmodule

// ===== verification/stf_src_model.sv
// behavioural sample source with trigger pulses and gate level for the sequencer
module stf_src_model (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // commands from the bench
  input  wire logic        cmd_go,
  input  wire logic        cmd_slow,
  input  wire logic        cmd_gate,
  input  wire logic [15:0] cmd_len,
  input  wire logic [7:0]  cmd_mask,
  // towards the sequencer
  output logic             smp_valid,
  output logic [15:0]      smp_data,
  output logic [7:0]       trg_src,
  output logic             gate_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt_q;
  logic [7:0]  msk_q;
  logic        ph_q;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q    <= 16'h0000;
      msk_q    <= 8'h00;
      ph_q     <= 1'b0;
      smp_data <= 16'h0000;
    end else begin
      ph_q <= ~ph_q;
      if (smp_valid) smp_data <= smp_data + 16'h0001;
      if (cmd_go) begin
        // a source never gives pulses shorter than two clocks
        cnt_q <= (cmd_len < 16'h0002) ? 16'h0002 : cmd_len;
        msk_q <= cmd_mask;
      end else if (cnt_q != 16'h0000) cnt_q <= cnt_q - 16'h0001;
    end
  end
  // slow pacing gives one sample every other clock
  assign smp_valid = cmd_slow ? ph_q : 1'b1;
  assign trg_src   = (cnt_q != 16'h0000) ? msk_q : 8'h00;
  assign gate_in   = cmd_gate;
endmodule

// ===== verification/tb_top.sv
// self-checking bench for the trigger and acquisition sequencer
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import stf_pkg::*;
  logic sys_clk = 1'b0, nrst = 1'b0, go = 1'b0, slow = 1'b0, gate = 1'b0;
  logic [15:0] plen = 16'h0000;
  logic [7:0] pmask = 8'h00, prev_src = 8'h00;
  stf_bus_type avs_req = '0;
  logic [31:0] avs_readdata, rdv;
  logic avs_waitrequest, smp_valid, gate_in, trig_out, fifo_irq, sync_out, sync_prev;
  logic [STF_DW-1:0] smp_data;
  logic [7:0] trg_src;
  stf_mem_type fast_mem, slow_mem;
  stf_ts_type ts_mem;
  int fail_count = 0, n_tests = 0, cyc = 0, t_rise, t_out, r0, r1;
  int n_to, n_ts, n_irq, n_slow, n_sync, n_fast;
  logic [STF_AW-1:0] fa_hit;
  logic [47:0] stq[$];
  logic [15:0] sgq[$];
  always #2 sys_clk = ~sys_clk;
  stf_acq #(.NSRC(8)) stf_acq_i (.sys_clk(sys_clk), .nrst(nrst), .avs_req(avs_req), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .smp_valid(smp_valid), .smp_data(smp_data), .trg_src(trg_src),
    .gate_in(gate_in), .fast_mem(fast_mem), .slow_mem(slow_mem), .ts_mem(ts_mem), .trig_out(trig_out),
    .fifo_irq(fifo_irq), .sync_out(sync_out));
  stf_src_model stf_src_model_i (.sys_clk(sys_clk), .nrst(nrst), .cmd_go(go), .cmd_slow(slow), .cmd_gate(gate),
    .cmd_len(plen), .cmd_mask(pmask), .smp_valid(smp_valid), .smp_data(smp_data), .trg_src(trg_src),
    .gate_in(gate_in));
  // ****************************************
  // monitor and timeout
  // ****************************************
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (trg_src[0] && !prev_src[0]) t_rise = cyc;
    prev_src = trg_src;
    if (trig_out === 1'b1) begin
      n_to = n_to + 1;
      t_out = cyc;
    end
    if (ts_mem.we === 1'b1) begin
      n_ts = n_ts + 1;
      fa_hit = fast_mem.addr;
      stq.push_back(ts_mem.stamp);
      sgq.push_back(ts_mem.seg);
    end
    if (fifo_irq === 1'b1) n_irq = n_irq + 1;
    if (slow_mem.we === 1'b1) n_slow = n_slow + 1;
    if (fast_mem.we === 1'b1) n_fast = n_fast + 1;
    if (sync_out !== sync_prev) n_sync = n_sync + 1;
    sync_prev = sync_out;
    // whole run needs well under two thousand cycles
    if (cyc > 20000) begin
      fail_count = fail_count + 1;
      results();
    end
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic results();
    $display("tests %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic rd, input logic [5:0] a, input logic [31:0] d);
    avs_req <= '{read: rd, write: ~rd, address: a, writedata: d, byteenable: 4'hf};
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rdv = avs_readdata;
    avs_req <= '0;
    @(posedge sys_clk);
  endtask
  function automatic logic [31:0] mk(input logic [2:0] m, input logic t, input logic [1:0] e, input logic a,
                                     input logic [1:0] p);
    mk = 32'(m) | (32'h1 << CB_START) | (32'(t) << CB_TOEN) | (32'(e) << CB_EDGE) | (32'(a) << CB_AND)
         | (32'(p) << CB_PWM);
  endfunction
  task automatic run(input logic [31:0] c);
    acc(1'b0, OFS_CTRL, 32'h0000_0010);
    acc(1'b0, OFS_CTRL, c);
    repeat (8) @(posedge sys_clk);
    n_to = 0;
    n_ts = 0;
    stq.delete();
    sgq.delete();
  endtask
  task automatic pulse(input logic [7:0] m, input logic [15:0] l);
    pmask <= m;
    plen  <= l;
    go    <= 1'b1;
    @(posedge sys_clk);
    go <= 1'b0;
    repeat (int'(l) + 4) @(posedge sys_clk);
  endtask
  // counts over a window sampled off the active edge, so no race with the monitor
  task automatic window(input int n);
    @(negedge sys_clk);
    n_irq  = 0;
    n_slow = 0;
    n_sync = 0;
    n_fast = 0;
    repeat (n) @(negedge sys_clk);
    @(posedge sys_clk);
  endtask
  // ****************************************
  // tests
  // ****************************************
  logic [5:0] ofs[4] = '{OFS_DELAY, OFS_PWID, OFS_SLDIV, OFS_SYDIV};
  logic [31:0] val[4] = '{32'h0000_ffff, 32'h0000_ffff, 32'h0007_fff8, 32'h0000_1ffe};
  logic [1:0] pwm[4] = '{PW_LONG, PW_LONG, PW_SHORT, PW_SHORT};
  logic [15:0] pwl[4] = '{16'h0003, 16'h0008, 16'h0002, 16'h0008};
  initial begin
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    acc(1'b1, 6'h3c, 32'h0000_0000);
    chk(48'(rdv), 48'h0);
    for (int i = 0; i < 4; i++) begin
      acc(1'b0, ofs[i], val[i]);
      acc(1'b1, ofs[i], 32'h0000_0000);
      chk(48'(rdv), 48'(val[i]));
    end
    acc(1'b0, OFS_DELAY, 32'h0000_0000);
    acc(1'b0, OFS_SYDIV, 32'h0000_0008);
    window(64);
    chk(48'(n_sync), 48'd16);
    acc(1'b0, OFS_MEMSZ, 32'h0000_0020);
    acc(1'b0, OFS_SEGSZ, 32'h0000_0010);
    acc(1'b0, OFS_PRE, 32'h0000_0004);
    acc(1'b0, OFS_POSTL, 32'h0000_1000);
    acc(1'b0, OFS_TMASK, 32'h0000_0001);
    for (int e = 0; e < 3; e++) begin
      run(mk(MD_RING, 1'b1, 2'(e), 1'b0, 2'h0));
      pulse(8'h01, 16'h0006);
      chk(48'(n_to), (e == 2) ? 48'd2 : 48'd1);
      if (e == 0) chk(48'(t_out - t_rise), 48'd1);
    end
    run(mk(MD_RING, 1'b0, ED_RISE, 1'b0, 2'h0));
    pulse(8'h01, 16'h0006);
    chk(48'(n_to), 48'd0);
    acc(1'b0, OFS_TMASK, 32'h0000_0003);
    run(mk(MD_RING, 1'b1, ED_RISE, 1'b1, 2'h0));
    pulse(8'h01, 16'h0006);
    chk(48'(n_to), 48'd0);
    pulse(8'h03, 16'h0006);
    chk(48'(n_to), 48'd1);
    run(mk(MD_RING, 1'b1, ED_RISE, 1'b0, 2'h0));
    pulse(8'h02, 16'h0006);
    chk(48'(n_to), 48'd1);
    acc(1'b0, OFS_TMASK, 32'h0000_0001);
    acc(1'b0, OFS_DELAY, 32'h0000_0005);
    run(mk(MD_RING, 1'b1, ED_RISE, 1'b0, 2'h0));
    pulse(8'h01, 16'h0003);
    repeat (6) @(posedge sys_clk);
    chk(48'(t_out - t_rise), 48'd6);
    acc(1'b0, OFS_DELAY, 32'h0000_0000);
    acc(1'b0, OFS_PWID, 32'h0000_0004);
    for (int i = 0; i < 4; i++) begin
      run(mk(MD_RING, 1'b1, ED_RISE, 1'b0, pwm[i]));
      pulse(8'h01, pwl[i]);
      chk(48'(n_to), 48'(i % 3 == 0 ? 0 : 1));
    end
    acc(1'b0, OFS_PWID, 32'h0000_0000);
    acc(1'b0, OFS_POSTL, 32'h0000_000c);
    run(mk(MD_SEG, 1'b1, ED_RISE, 1'b0, 2'h0));
    pulse(8'h01, 16'h0003);
    r0 = t_rise;
    repeat (16) @(posedge sys_clk);
    pulse(8'h01, 16'h0003);
    r1 = t_rise;
    repeat (30) @(posedge sys_clk);
    chk(48'(n_ts), 48'd2);
    if (n_ts == 2) begin
      chk(48'(sgq[1] - sgq[0]), 48'd1);
      chk(stq[1] - stq[0], 48'(r1 - r0));
      chk(48'(fa_hit >> 4), 48'd1);
    end
    // gate is active low here: two intervals fill both segments
    gate <= 1'b1;
    run(mk(MD_GATE, 1'b0, ED_RISE, 1'b0, 2'h0));
    repeat (2) begin
      gate <= 1'b0;
      repeat (8) @(posedge sys_clk);
      gate <= 1'b1;
      repeat (24) @(posedge sys_clk);
    end
    acc(1'b1, OFS_STATUS, 32'h0000_0000);
    chk(48'(rdv), 48'h0000_0002_0010);
    chk(48'(n_ts), 48'd2);
    run(mk(MD_FIFO, 1'b0, ED_RISE, 1'b0, 2'h0));
    window(64);
    chk(48'(n_irq), 48'd4);
    chk(48'(n_fast), 48'd64);
    acc(1'b0, OFS_SLDIV, 32'h0000_0008);
    run(mk(MD_DUAL, 1'b0, ED_RISE, 1'b0, 2'h0));
    window(64);
    chk(48'(n_slow), 48'd8);
    slow <= 1'b1;
    repeat (16) @(posedge sys_clk);
    window(128);
    chk(48'(n_slow), 48'd8);
    results();
  end
endmodule
